// file: rtl/pwrup_diag_map.svh
`ifndef PWRUP_DIAG_MAP_SVH
`define PWRUP_DIAG_MAP_SVH

// Clock rate
`define PD_CLK_MHZ 100

// Settle time of each power-on check
`define PD_CHECK_US 10
`define PD_CHECK_CYCLES (`PD_CHECK_US * `PD_CLK_MHZ)

// Time each active code stays on the display
`define PD_DWELL_MS 1000
`define PD_DWELL_CYCLES (`PD_DWELL_MS * 1000 * `PD_CLK_MHZ)

// Display codes, two BCD digits
`define PD_CODE_WARN_ACTUATOR 8'h99
`define PD_CODE_AL_MULTI_TURN 8'h81
`define PD_CODE_AL_SYS_FAIL 8'h53
`define PD_CODE_AL_ENC_DISC 8'h50
`define PD_CODE_AL_COMMUTATION 8'h52
`define PD_CODE_SPEED 8'h00

// Slot positions of the active-code mask
`define PD_SLOT_WARN99 0
`define PD_SLOT_AL81 1
`define PD_SLOT_AL53 2
`define PD_SLOT_AL50 3
`define PD_SLOT_AL52 4
`define PD_SLOTS 5

`endif

// file: rtl/pwrup_diag_pkg.sv
`default_nettype none
package pwrup_diag_pkg;

    typedef enum logic [1:0] {
        ENC_ABS17 = 2'b00,
        ENC_ABS13 = 2'b01,
        ENC_INC_PAIRED = 2'b10,
        ENC_INC_WIRED = 2'b11
    } enc_type_t;

    typedef enum logic [2:0] {
        SEQ_LATCH = 3'b000,
        SEQ_VOLTAGE = 3'b001,
        SEQ_PAIRING = 3'b010,
        SEQ_MULTI_TURN = 3'b011,
        SEQ_WIRING = 3'b100,
        SEQ_STATUS = 3'b101
    } seq_state_t;

    typedef struct packed {
        logic [2:0] slot;
        logic slotValid;
    } rot_state_t;

    typedef struct packed {
        seq_state_t seq;
        logic [15:0] settleCnt;
        enc_type_t encType;
        logic warn99;
        logic al81;
        logic al53;
        logic al50;
        logic al52;
        logic systemDown;
        logic clearAccepted;
        logic statusMode;
        logic driveEnable;
        logic [7:0] gatedInputs;
        logic estopOut;
        logic rs232Active;
        logic rs485Active;
        logic [7:0] dispCode;
        logic dispAlarm;
        logic dispSpeed;
        logic [31:0] dwellCnt;
        logic dwellTick;
    } diag_state_t;

endpackage
`default_nettype wire

// file: rtl/alarm_rotator.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwrup_diag_map.svh"

module alarm_rotator #(
    parameter int unsigned SLOTS = `PD_SLOTS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [SLOTS-1:0] activeMask,
    input wire logic step,
    output logic [2:0] slot,
    output logic slotValid
);

    pwrup_diag_pkg::rot_state_t r;
    pwrup_diag_pkg::rot_state_t next_r;

    // First set slot after start, wrapping round; start itself is tried last
    function automatic logic [2:0] nextSet(input logic [SLOTS-1:0] mask, input logic [2:0] start);
        logic [2:0] found;
        logic hit;
        int unsigned k;
        found = start;
        hit = 1'b0;
        for (int i = 1; i <= SLOTS; i++) begin
            k = (int'(start) + i) % SLOTS;
            if (!hit && mask[k]) begin
                found = k[2:0];
                hit = 1'b1;
            end
        end
        return found;
    endfunction

    always_comb begin
        next_r = r;
        if (activeMask == '0) begin
            next_r.slotValid = 1'b0;
            next_r.slot = 3'h0;
        end else if (!r.slotValid || !activeMask[r.slot] || step) begin
            next_r.slot = nextSet(activeMask, r.slotValid ? r.slot : 3'(SLOTS - 1));
            next_r.slotValid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign slot = r.slot;
    assign slotValid = r.slotValid;

endmodule

`default_nettype wire

// file: rtl/servo_powerup_diagnostics.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwrup_diag_map.svh"

module servo_powerup_diagnostics #(
    parameter int unsigned CHECK_CYCLES = `PD_CHECK_CYCLES,
    parameter int unsigned DWELL_CYCLES = `PD_DWELL_CYCLES,
    parameter int unsigned IN_WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] encoderType,
    input wire logic supplyVoltageOk,
    input wire logic actuatorMatch,
    input wire logic multiTurnValid,
    input wire logic phaseAbzOk,
    input wire logic commutationPhaseSignalsOk,
    input wire logic encoderSupplyOk,
    input wire logic multiTurnClearFunction,
    input wire logic jogActive,
    input wire logic emergencyStop,
    input wire logic [IN_WIDTH-1:0] extInputs,
    input wire logic firstAxis,
    output logic statusMode,
    output logic displayShowsSpeed,
    output logic [7:0] displayCode,
    output logic displayIsAlarm,
    output logic warnActuatorMismatch,
    output logic alarmMultiTurn,
    output logic alarmSystemFailure,
    output logic alarmEncoderDisconnect,
    output logic alarmCommutation,
    output logic systemDown,
    output logic driveEnable,
    output logic multiTurnClearAccepted,
    output logic [IN_WIDTH-1:0] gatedInputs,
    output logic emergencyStopOut,
    output logic serialRs232Active,
    output logic serialRs485Active
);

    pwrup_diag_pkg::diag_state_t s;
    pwrup_diag_pkg::diag_state_t next_s;

    logic [2:0] rotSlot;
    logic rotValid;
    logic [`PD_SLOTS-1:0] activeMask;

    // Display code for a rotator slot
    function automatic logic [7:0] codeOf(input logic [2:0] slotIdx);
        logic [7:0] c;
        case (slotIdx)
            3'(`PD_SLOT_WARN99): c = `PD_CODE_WARN_ACTUATOR;
            3'(`PD_SLOT_AL81): c = `PD_CODE_AL_MULTI_TURN;
            3'(`PD_SLOT_AL53): c = `PD_CODE_AL_SYS_FAIL;
            3'(`PD_SLOT_AL50): c = `PD_CODE_AL_ENC_DISC;
            3'(`PD_SLOT_AL52): c = `PD_CODE_AL_COMMUTATION;
            default: c = `PD_CODE_SPEED;
        endcase
        return c;
    endfunction

    // Absolute encoders carry multi-turn data
    function automatic logic isAbsolute(input pwrup_diag_pkg::enc_type_t t);
        return (t == pwrup_diag_pkg::ENC_ABS17) || (t == pwrup_diag_pkg::ENC_ABS13);
    endfunction

    always_comb begin
        activeMask = '0;
        activeMask[`PD_SLOT_WARN99] = s.warn99;
        activeMask[`PD_SLOT_AL81] = s.al81;
        activeMask[`PD_SLOT_AL53] = s.al53;
        activeMask[`PD_SLOT_AL50] = s.al50;
        activeMask[`PD_SLOT_AL52] = s.al52;
    end

    alarm_rotator #(
        .SLOTS(`PD_SLOTS)
    ) u_rotator (
        .clk(clk),
        .rst(rst),
        .activeMask(activeMask),
        .step(s.dwellTick),
        .slot(rotSlot),
        .slotValid(rotValid)
    );

    always_comb begin
        next_s = s;
        next_s.dwellTick = 1'b0;

        // Settle counter for each check step
        if (s.settleCnt != 16'h0000) begin
            next_s.settleCnt = s.settleCnt - 16'h0001;
        end

        case (s.seq)
            pwrup_diag_pkg::SEQ_LATCH: begin
                next_s.encType = pwrup_diag_pkg::enc_type_t'(encoderType);
                next_s.settleCnt = 16'(CHECK_CYCLES - 1);
                next_s.seq = pwrup_diag_pkg::SEQ_VOLTAGE;
            end
            pwrup_diag_pkg::SEQ_VOLTAGE: begin
                // Wait for a sound input voltage before going on
                if (s.settleCnt == 16'h0000 && supplyVoltageOk) begin
                    next_s.settleCnt = 16'(CHECK_CYCLES - 1);
                    case (s.encType)
                        pwrup_diag_pkg::ENC_ABS17: next_s.seq = pwrup_diag_pkg::SEQ_PAIRING;
                        pwrup_diag_pkg::ENC_ABS13: next_s.seq = pwrup_diag_pkg::SEQ_MULTI_TURN;
                        pwrup_diag_pkg::ENC_INC_PAIRED: next_s.seq = pwrup_diag_pkg::SEQ_PAIRING;
                        default: next_s.seq = pwrup_diag_pkg::SEQ_WIRING;
                    endcase
                end
            end
            pwrup_diag_pkg::SEQ_PAIRING: begin
                if (s.settleCnt == 16'h0000) begin
                    if (!actuatorMatch) begin
                        next_s.warn99 = 1'b1;
                    end
                    next_s.settleCnt = 16'(CHECK_CYCLES - 1);
                    if (s.encType == pwrup_diag_pkg::ENC_ABS17) begin
                        next_s.seq = pwrup_diag_pkg::SEQ_MULTI_TURN;
                    end else begin
                        next_s.seq = pwrup_diag_pkg::SEQ_STATUS;
                    end
                end
            end
            pwrup_diag_pkg::SEQ_MULTI_TURN: begin
                if (s.settleCnt == 16'h0000) begin
                    if (!multiTurnValid) begin
                        if (s.encType == pwrup_diag_pkg::ENC_ABS17) begin
                            next_s.al81 = 1'b1;
                        end else begin
                            next_s.al53 = 1'b1;
                        end
                        next_s.systemDown = 1'b1;
                    end
                    next_s.seq = pwrup_diag_pkg::SEQ_STATUS;
                end
            end
            pwrup_diag_pkg::SEQ_WIRING: begin
                if (s.settleCnt == 16'h0000) begin
                    next_s.seq = pwrup_diag_pkg::SEQ_STATUS;
                end
            end
            pwrup_diag_pkg::SEQ_STATUS: begin
                next_s.statusMode = 1'b1;
            end
            default: begin
                next_s.seq = pwrup_diag_pkg::SEQ_LATCH;
            end
        endcase

        // Wiring faults of a wired incremental encoder (ENC_INC_WIRED) are watched from the end of the wiring check on
        if (s.encType == pwrup_diag_pkg::ENC_INC_WIRED &&
            (s.seq == pwrup_diag_pkg::SEQ_WIRING || s.seq == pwrup_diag_pkg::SEQ_STATUS) &&
            (s.seq == pwrup_diag_pkg::SEQ_STATUS || s.settleCnt == 16'h0000)) begin
            if (!phaseAbzOk || !commutationPhaseSignalsOk || !encoderSupplyOk) begin
                next_s.al50 = 1'b1;
            end
            if (!commutationPhaseSignalsOk || !encoderSupplyOk) begin
                next_s.al52 = 1'b1;
            end
        end

        // Clear command is noted for absolute encoders only; the alarm itself stays until power is cycled
        if (multiTurnClearFunction && isAbsolute(s.encType)) begin
            next_s.clearAccepted = 1'b1;
        end

        // Divider that paces the code rotation
        if (s.statusMode) begin
            if (s.dwellCnt == 32'h0000_0000) begin
                next_s.dwellCnt = 32'(DWELL_CYCLES - 1);
                next_s.dwellTick = 1'b1;
            end else begin
                next_s.dwellCnt = s.dwellCnt - 32'h0000_0001;
            end
        end else begin
            // Preload so the first code also stands a full dwell
            next_s.dwellCnt = 32'(DWELL_CYCLES - 1);
        end

        // Display: speed by default, otherwise the current active code
        if (s.statusMode && rotValid) begin
            next_s.dispCode = codeOf(rotSlot);
            next_s.dispAlarm = (rotSlot != 3'(`PD_SLOT_WARN99));
            next_s.dispSpeed = 1'b0;
        end else begin
            next_s.dispCode = `PD_CODE_SPEED;
            next_s.dispAlarm = 1'b0;
            next_s.dispSpeed = s.statusMode;
        end

        // Drive stays off while down, before status mode, and under emergency stop
        next_s.driveEnable = s.statusMode && !s.systemDown && !next_s.systemDown &&
            !emergencyStop;

        // In JOG only emergency stop is honoured
        next_s.gatedInputs = jogActive ? '0 : extInputs;
        next_s.estopOut = emergencyStop;

        next_s.rs232Active = firstAxis;
        next_s.rs485Active = !firstAxis;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.seq <= pwrup_diag_pkg::SEQ_LATCH;
            s.encType <= pwrup_diag_pkg::ENC_ABS17;
            s.dispCode <= `PD_CODE_SPEED;
        end else begin
            s <= next_s;
        end
    end

    assign statusMode = s.statusMode;
    assign displayShowsSpeed = s.dispSpeed;
    assign displayCode = s.dispCode;
    assign displayIsAlarm = s.dispAlarm;
    assign warnActuatorMismatch = s.warn99;
    assign alarmMultiTurn = s.al81;
    assign alarmSystemFailure = s.al53;
    assign alarmEncoderDisconnect = s.al50;
    assign alarmCommutation = s.al52;
    assign systemDown = s.systemDown;
    assign driveEnable = s.driveEnable;
    assign multiTurnClearAccepted = s.clearAccepted;
    assign gatedInputs = s.gatedInputs;
    assign emergencyStopOut = s.estopOut;
    assign serialRs232Active = s.rs232Active;
    assign serialRs485Active = s.rs485Active;

endmodule

`default_nettype wire

// file: bench/servo_diag_checker.sv
`timescale 1ns/1ps
`default_nettype none
module servo_diag_checker #(
    parameter int unsigned IN_WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic jogActive,
    input wire logic emergencyStop,
    input wire logic [IN_WIDTH-1:0] extInputs,
    input wire logic firstAxis,
    input wire logic statusMode,
    input wire logic displayShowsSpeed,
    input wire logic [7:0] displayCode,
    input wire logic displayIsAlarm,
    input wire logic warnActuatorMismatch,
    input wire logic alarmMultiTurn,
    input wire logic alarmSystemFailure,
    input wire logic alarmEncoderDisconnect,
    input wire logic alarmCommutation,
    input wire logic systemDown,
    input wire logic driveEnable,
    input wire logic [IN_WIDTH-1:0] gatedInputs,
    input wire logic emergencyStopOut,
    input wire logic serialRs232Active,
    input wire logic serialRs485Active
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [5:0] flags;
    assign flags = {warnActuatorMismatch, alarmMultiTurn, alarmSystemFailure,
        alarmEncoderDisconnect, alarmCommutation, systemDown};
    sequence downRise;
        $rose(systemDown);
    endsequence
    sequence statusReached;
        ##[0:6] statusMode;
    endsequence
    jog_gate_a: assert property (!$past(rst) && jogActive |=> gatedInputs == '0)
        else $error("gated inputs not zero during jog");
    input_pass_a: assert property (!$past(rst) && !jogActive |=>
        gatedInputs == $past(extInputs))
        else $error("gated inputs do not follow external inputs");
    estop_pass_a: assert property (!$past(rst) |=>
        emergencyStopOut == $past(emergencyStop))
        else $error("emergency stop not passed through");
    serial_link_a: assert property (!$past(rst) |=>
        serialRs232Active == $past(firstAxis) && serialRs485Active != $past(firstAxis))
        else $error("serial link choice wrong");
    flags_sticky_a: assert property (!$past(rst) |-> ($past(flags) & ~flags) == '0)
        else $error("alarm flag dropped without reset");
    down_cause_a: assert property (downRise |-> alarmMultiTurn || alarmSystemFailure)
        else $error("system down without multi-turn alarm");
    down_status_a: assert property (downRise |-> statusReached)
        else $error("status mode not reached after down");
    drive_gate_a: assert property (!$past(rst) |=>
        driveEnable == ($past(statusMode) && !$past(systemDown) && !$past(emergencyStop)))
        else $error("drive enable wrong");
    speed_shown_a: assert property (displayShowsSpeed |->
        statusMode && displayCode == 8'h00)
        else $error("speed shown outside status mode");
    code_owner_a: assert property (
        statusMode && !displayShowsSpeed && displayCode != 8'h00 |->
        (displayCode == 8'h99 && warnActuatorMismatch && !displayIsAlarm) ||
        (displayCode == 8'h81 && alarmMultiTurn && displayIsAlarm) ||
        (displayCode == 8'h53 && alarmSystemFailure && displayIsAlarm) ||
        (displayCode == 8'h50 && alarmEncoderDisconnect && displayIsAlarm) ||
        (displayCode == 8'h52 && alarmCommutation && displayIsAlarm))
        else $error("displayed code not an active code");
endmodule
bind servo_powerup_diagnostics servo_diag_checker #(.IN_WIDTH(IN_WIDTH)) checker_inst (.*);
`default_nettype wire

// file: bench/encoder_partner.sv
`timescale 1ns/1ps
`default_nettype none
module encoder_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic loseData,
    input wire logic [3:0] faults,
    input wire logic clearSeen,
    output logic actuatorMatch,
    output logic multiTurnValid,
    output logic phaseAbzOk,
    output logic commutationPhaseSignalsOk,
    output logic encoderSupplyOk
);
    logic armed = 1'b0;
    initial multiTurnValid = 1'b1;
    always @(posedge clk) begin
        if (loseData) multiTurnValid <= 1'b0;
        else if (rst && armed) multiTurnValid <= 1'b1;
        if (rst) armed <= 1'b0;
        else if (clearSeen) armed <= 1'b1;
    end
    assign {actuatorMatch, phaseAbzOk, commutationPhaseSignalsOk, encoderSupplyOk} = ~faults;
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int CK = 4;
    localparam int DW = 8;
    logic clk = 1'b0, rst = 1'b1, supplyVoltageOk = 1'b0, multiTurnClearFunction = 1'b0;
    logic jogActive = 1'b0, emergencyStop = 1'b0, firstAxis = 1'b0, loseData = 1'b0;
    logic [1:0] encoderType = 2'b00;
    logic [3:0] faults = 4'h0;
    logic [7:0] extInputs = 8'h00, displayCode, gatedInputs, ef, e;
    logic actuatorMatch, multiTurnValid, phaseAbzOk, commutationPhaseSignalsOk, encoderSupplyOk;
    logic statusMode, displayShowsSpeed, displayIsAlarm, warnActuatorMismatch, alarmMultiTurn;
    logic alarmSystemFailure, alarmEncoderDisconnect, alarmCommutation, systemDown, driveEnable;
    logic multiTurnClearAccepted, emergencyStopOut, serialRs232Active, serialRs485Active;
    int err_count = 0, checks_done = 0, mtOk = 1, armed = 0;
    logic [7:0] expq[$], seen[$];
    logic [7:0] codes [5] = '{8'h99, 8'h81, 8'h53, 8'h50, 8'h52};
    logic [7:0] cases [8] = '{8'h00, 8'h31, 8'h50, 8'h60, 8'h91, 8'hC8, 8'hC4, 8'hC2};
    servo_powerup_diagnostics #(.CHECK_CYCLES(CK), .DWELL_CYCLES(DW))
        servo_powerup_diagnostics_inst (.*);
    encoder_partner encoder_partner_inst (.clearSeen(multiTurnClearAccepted), .*);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        extInputs <= 8'($urandom);
        jogActive <= 1'($urandom);
    end
    task automatic chk(string name, logic [7:0] x, logic [7:0] s);
        checks_done++;
        if (s !== x) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, x, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic run_case(logic [7:0] c);
        logic [1:0] t;
        int k, last, start;
        t = c[7:6];
        if (armed) mtOk = 1;
        armed = 0;
        if (c[5]) mtOk = 0;
        @(posedge clk);
        rst <= 1'b1;
        encoderType <= t;
        loseData <= c[5];
        faults <= c[4:1];
        firstAxis <= 1'($urandom);
        supplyVoltageOk <= 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4 * CK) @(posedge clk);
        chk("statusMode", 0, statusMode);
        supplyVoltageOk <= 1'b1;
        for (k = 0; k < 200 && statusMode !== 1'b1; k++) @(posedge clk);
        ef = {3'b000, 1'(t[0] == 1'b0 && c[4]), 1'(t == 2'b00 && mtOk == 0),
            1'(t == 2'b01 && mtOk == 0), 1'(t == 2'b11 && c[3:1] != 0), 1'(t == 2'b11 && c[2:1] != 0)};
        repeat (4) @(posedge clk);
        chk("statusMode", 1, statusMode);
        chk("alarms", ef, {3'b000, warnActuatorMismatch, alarmMultiTurn, alarmSystemFailure,
            alarmEncoderDisconnect, alarmCommutation});
        chk("systemDown", ef[3] | ef[2], systemDown);
        chk("driveEnable", !(ef[3] | ef[2]), driveEnable);
        emergencyStop <= 1'b1;
        repeat (2) @(posedge clk);
        chk("driveEnable estop", 0, driveEnable);
        emergencyStop <= 1'b0;
        if (c[0]) begin
            multiTurnClearFunction <= 1'b1;
            @(posedge clk);
            multiTurnClearFunction <= 1'b0;
            repeat (2) @(posedge clk);
            chk("clearAccepted", t[1] == 1'b0, multiTurnClearAccepted);
            chk("alarmMultiTurn kept", ef[3], alarmMultiTurn);
            armed = (t[1] == 1'b0);
        end
        expq = {};
        for (k = 0; k < 5; k++) if (ef[4 - k]) expq.push_back(codes[k]);
        if (expq.size() == 0) expq.push_back(8'h00);
        seen = {};
        last = 0;
        for (k = 0; k < DW * 12; k++) begin
            @(negedge clk);
            if (seen.size() == 0 || displayCode !== seen[$]) begin
                if (seen.size() > 1) chk("dwell", DW, 8'(k - last));
                seen.push_back(displayCode);
                last = k;
            end
        end
        start = 0;
        foreach (expq[i]) if (expq[i] == seen[0]) start = i;
        foreach (seen[i]) chk("displayCode", expq[(start + i) % expq.size()], seen[i]);
        e = expq[(start + seen.size() - 1) % expq.size()];
        chk("isAlarm", e != 8'h99 && e != 8'h00, displayIsAlarm);
        chk("showsSpeed", ef == 0, displayShowsSpeed);
        $display("case %h done", c);
    endtask
    initial begin
        void'($urandom(61));
        foreach (cases[i]) run_case(cases[i]);
        final_report();
    end
    initial begin
        #200_000;
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
